// ---- design/ccos_regs.svh ----
`ifndef CCOS_REGS_SVH
`define CCOS_REGS_SVH

// Register byte addresses
`define CCOS_ADDR_W           16
`define CCOS_ADDR_FIRST_CFG   16'hfe79
`define CCOS_ADDR_SECOND_CFG  16'hfe7a
`define CCOS_ADDR_THIRD_CFG   16'hfe7b
`define CCOS_ADDR_STATUS      16'hfe90

// Reset values
`define CCOS_RST_FIRST_CFG    8'h00
`define CCOS_RST_SECOND_CFG   8'h00
`define CCOS_RST_THIRD_CFG    8'h00
`define CCOS_RDATA_IDLE       8'h00

// On-request selection codes
`define CCOS_SEL_ALWAYS       2'h0
`define CCOS_SEL_PIN          2'h1
`define CCOS_SEL_SOFT         2'h2
`define CCOS_SEL_BOTH         2'h3

// Delay selection codes
`define CCOS_DLY_NONE         2'h0
`define CCOS_DLY_SHORT        2'h1
`define CCOS_DLY_MID          2'h2
`define CCOS_DLY_LONG         2'h3

// Channel indices
`define CCOS_NUM_CH           3
`define CCOS_CH_A             0
`define CCOS_CH_B             1
`define CCOS_CH_C             2

// Timing, in the printed units, and the clock rate
`define CCOS_CLK_HZ           10000000
`define CCOS_HZ_PER_KHZ       1000
`define CCOS_T_SHORT_MS       50
`define CCOS_T_MID_MS         250
`define CCOS_T_LONG_MS        1000
`define CCOS_CNT_W            24

`endif

// ---- design/ccos_pkg.sv ----
package ccos_pkg;

   // Layout of the first and second channel setting registers
   typedef struct packed {
      logic       pin_invert;
      logic       soft_on;
      logic [1:0] req_sel;
      logic [1:0] on_dly;
      logic [1:0] off_dly;
   } ccos_ab_cfg_t;

   // Layout of the third channel and re-enable register
   typedef struct packed {
      logic       extra_c;
      logic       extra_b;
      logic       extra_a;
      logic       src_sel;
      logic [1:0] on_dly;
      logic [1:0] off_dly;
   } ccos_c_cfg_t;

   // Read-only status layout
   typedef struct packed {
      logic [1:0] unused;
      logic [2:0] req;
      logic [2:0] en;
   } ccos_status_t;

   typedef enum logic [2:0] {
      CCOS_IDLE,
      CCOS_ON_WAIT,
      CCOS_RUN,
      CCOS_OFF_WAIT,
      CCOS_FAULT,
      CCOS_EXTRA_WAIT
   } ccos_state_t;

endpackage

// ---- design/ccos_sync2.sv ----
`timescale 1ns/10ps
module ccos_sync2 #(
   parameter int unsigned WIDTH = 2
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else if (ce_i) begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule // ccos_sync2

// ---- design/ccos_delay_timer.sv ----
`timescale 1ns/10ps
`include "ccos_regs.svh"
module ccos_delay_timer #(
   parameter int unsigned       CNT_W     = `CCOS_CNT_W,
   parameter logic [CNT_W-1:0]  SHORT_CYC = CNT_W'(500000),
   parameter logic [CNT_W-1:0]  MID_CYC   = CNT_W'(2500000),
   parameter logic [CNT_W-1:0]  LONG_CYC  = CNT_W'(10000000)
) (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       load_i,
   input  wire logic [1:0] code_i,
   output logic            done_o
);
   logic [CNT_W-1:0] cnt;
   logic             run;

   function automatic logic [CNT_W-1:0] delay_cycles(input logic [1:0] code);
      unique case (code)
         `CCOS_DLY_NONE:  delay_cycles = '0;
         `CCOS_DLY_SHORT: delay_cycles = SHORT_CYC;
         `CCOS_DLY_MID:   delay_cycles = MID_CYC;
         `CCOS_DLY_LONG:  delay_cycles = LONG_CYC;
      endcase
   endfunction

   // A new load restarts the count and discards any run in progress
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cnt    <= '0;
         run    <= 1'b0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (load_i) begin
            cnt <= delay_cycles(code_i);
            run <= 1'b1;
         end else if (run) begin
            if (cnt == '0) begin
               done_o <= 1'b1;
               run    <= 1'b0;
            end else begin
               cnt <= cnt - CNT_W'(1);
            end
         end
      end
   end
endmodule // ccos_delay_timer

// ---- design/ccos_sequencer.sv ----
// How it works
// - Bit 7 adds third channel delay after flag
// - Bit 6 adds second channel delay after flag
// - Bit 5 adds first channel delay after flag
// - Bit 4: first or second, else always on
// - Bits 3:2 set third channel start delay
// - Bits 1:0 set third channel off delay
// - Two-bit field forms first channel on-request
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`include "ccos_regs.svh"
module ccos_sequencer #(
   parameter int unsigned                 CNT_W     = `CCOS_CNT_W,
   parameter logic [`CCOS_CNT_W-1:0]      SHORT_CYC = `CCOS_CNT_W'(
      `CCOS_T_SHORT_MS * (`CCOS_CLK_HZ / `CCOS_HZ_PER_KHZ)),
   parameter logic [`CCOS_CNT_W-1:0]      MID_CYC   = `CCOS_CNT_W'(
      `CCOS_T_MID_MS * (`CCOS_CLK_HZ / `CCOS_HZ_PER_KHZ)),
   parameter logic [`CCOS_CNT_W-1:0]      LONG_CYC  = `CCOS_CNT_W'(
      `CCOS_T_LONG_MS * (`CCOS_CLK_HZ / `CCOS_HZ_PER_KHZ))
) (
   input  wire logic                    clk_sys_i,
   input  wire logic                    rst_i,
   input  wire logic                    ce_i,
   // Register port
   input  wire logic [`CCOS_ADDR_W-1:0] addr_i,
   input  wire logic [7:0]              wdata_i,
   input  wire logic                    wr_i,
   input  wire logic                    rd_i,
   output logic      [7:0]              rdata_o,
   // Device pins for the first and second channel on-requests
   input  wire logic                    first_channel_on_pin_i,
   input  wire logic                    second_channel_on_pin_i,
   // Protection flags, index 0 first channel, 2 third channel
   input  wire logic [2:0]              flag_active_i,
   input  wire logic [2:0]              reenable_done_i,
   // Sequencing results
   output logic      [2:0]              channel_enable_o,
   output logic      [2:0]              soft_start_o,
   output logic                         third_channel_on_request_o
);
   localparam int unsigned NCH = `CCOS_NUM_CH;

   ccos_pkg::ccos_ab_cfg_t first_cfg;
   ccos_pkg::ccos_ab_cfg_t second_cfg;
   ccos_pkg::ccos_c_cfg_t  third_cfg;
   ccos_pkg::ccos_status_t status;

   logic [1:0]       pin_sync;
   logic             first_channel_on_request;
   logic             second_channel_on_request;
   logic             third_channel_on_request;
   logic [NCH-1:0]   req;
   logic [NCH-1:0]   extra;
   logic [1:0]       on_code  [NCH];
   logic [1:0]       off_code [NCH];
   logic [NCH-1:0]   tmr_load;
   logic [1:0]       tmr_code [NCH];
   logic [NCH-1:0]   tmr_done;

   ccos_pkg::ccos_state_t state [NCH];

   // Pins come from outside the clock domain
   ccos_sync2 #(
      .WIDTH (2)
   ) u_pin_sync (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .async_i   ({second_channel_on_pin_i, first_channel_on_pin_i}),
      .sync_o    (pin_sync)
   );

   // Selects the on-request of the first or second channel
   function automatic logic form_request(input ccos_pkg::ccos_ab_cfg_t cfg,
                                         input logic pin);
      logic pin_on;
      pin_on = pin ^ cfg.pin_invert;
      unique case (cfg.req_sel)
         `CCOS_SEL_ALWAYS: form_request = 1'b1;
         `CCOS_SEL_PIN:    form_request = pin_on;
         `CCOS_SEL_SOFT:   form_request = cfg.soft_on;
         `CCOS_SEL_BOTH:   form_request = pin_on & cfg.soft_on;
      endcase
   endfunction

   always_comb begin
      first_channel_on_request  = form_request(first_cfg, pin_sync[0]);
      second_channel_on_request = form_request(second_cfg, pin_sync[1]);
      if (third_cfg.src_sel) begin
         third_channel_on_request = first_channel_on_request |
                                    second_channel_on_request;
      end else begin
         third_channel_on_request = 1'b1;
      end
   end

   // Per-channel views of the configuration
   always_comb begin
      req[`CCOS_CH_A]      = first_channel_on_request;
      req[`CCOS_CH_B]      = second_channel_on_request;
      req[`CCOS_CH_C]      = third_channel_on_request;
      extra[`CCOS_CH_A]    = third_cfg.extra_a;
      extra[`CCOS_CH_B]    = third_cfg.extra_b;
      extra[`CCOS_CH_C]    = third_cfg.extra_c;
      on_code[`CCOS_CH_A]  = first_cfg.on_dly;
      on_code[`CCOS_CH_B]  = second_cfg.on_dly;
      on_code[`CCOS_CH_C]  = third_cfg.on_dly;
      off_code[`CCOS_CH_A] = first_cfg.off_dly;
      off_code[`CCOS_CH_B] = second_cfg.off_dly;
      off_code[`CCOS_CH_C] = third_cfg.off_dly;
   end

   // Register writes
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         first_cfg  <= `CCOS_RST_FIRST_CFG;
         second_cfg <= `CCOS_RST_SECOND_CFG;
         third_cfg  <= `CCOS_RST_THIRD_CFG;
      end else if (ce_i && wr_i) begin
         unique case (addr_i)
            `CCOS_ADDR_FIRST_CFG:  first_cfg  <= wdata_i;
            `CCOS_ADDR_SECOND_CFG: second_cfg <= wdata_i;
            `CCOS_ADDR_THIRD_CFG:  third_cfg  <= wdata_i;
            default: ;
         endcase
      end
   end

   always_comb begin
      status        = '0;
      status.req    = req;
      status.en     = channel_enable_o;
   end

   // Register reads, data in the cycle after the strobe
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rdata_o <= `CCOS_RDATA_IDLE;
      end else if (ce_i) begin
         rdata_o <= `CCOS_RDATA_IDLE;
         if (rd_i) begin
            unique case (addr_i)
               `CCOS_ADDR_FIRST_CFG:  rdata_o <= first_cfg;
               `CCOS_ADDR_SECOND_CFG: rdata_o <= second_cfg;
               `CCOS_ADDR_THIRD_CFG:  rdata_o <= third_cfg;
               `CCOS_ADDR_STATUS:     rdata_o <= status;
               default:               rdata_o <= `CCOS_RDATA_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         third_channel_on_request_o <= 1'b0;
      end else if (ce_i) begin
         third_channel_on_request_o <= third_channel_on_request;
      end
   end

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      // Timer start, issued on the same edge as the state change so
      // that a stale expiry can never meet a freshly entered wait
      always_comb begin
         tmr_load[i] = 1'b0;
         tmr_code[i] = on_code[i];
         unique case (state[i])
            ccos_pkg::CCOS_IDLE: begin
               tmr_load[i] = req[i] & ~flag_active_i[i];
            end
            ccos_pkg::CCOS_RUN: begin
               tmr_load[i] = ~flag_active_i[i] & ~req[i];
               tmr_code[i] = off_code[i];
            end
            ccos_pkg::CCOS_FAULT: begin
               tmr_load[i] = reenable_done_i[i] & req[i] & extra[i];
            end
            default: ;
         endcase
      end

      ccos_delay_timer #(
         .CNT_W     (CNT_W),
         .SHORT_CYC (SHORT_CYC),
         .MID_CYC   (MID_CYC),
         .LONG_CYC  (LONG_CYC)
      ) u_timer (
         .clk_sys_i (clk_sys_i),
         .rst_i     (rst_i),
         .ce_i      (ce_i),
         .load_i    (tmr_load[i]),
         .code_i    (tmr_code[i]),
         .done_o    (tmr_done[i])
      );

      always_ff @(posedge clk_sys_i) begin
         if (rst_i) begin
            state[i]            <= ccos_pkg::CCOS_IDLE;
            channel_enable_o[i] <= 1'b0;
            soft_start_o[i]     <= 1'b0;
         end else if (ce_i) begin
            soft_start_o[i] <= 1'b0;
            unique case (state[i])
               ccos_pkg::CCOS_IDLE: begin
                  if (tmr_load[i]) begin
                     state[i] <= ccos_pkg::CCOS_ON_WAIT;
                  end
               end
               ccos_pkg::CCOS_ON_WAIT: begin
                  if (!req[i]) begin
                     state[i] <= ccos_pkg::CCOS_IDLE;
                  end else if (flag_active_i[i]) begin
                     state[i] <= ccos_pkg::CCOS_FAULT;
                  end else if (tmr_done[i]) begin
                     state[i]            <= ccos_pkg::CCOS_RUN;
                     channel_enable_o[i] <= 1'b1;
                     soft_start_o[i]     <= 1'b1;
                  end
               end
               ccos_pkg::CCOS_RUN: begin
                  if (flag_active_i[i]) begin
                     state[i]            <= ccos_pkg::CCOS_FAULT;
                     channel_enable_o[i] <= 1'b0;
                  end else if (!req[i]) begin
                     state[i] <= ccos_pkg::CCOS_OFF_WAIT;
                  end
               end
               ccos_pkg::CCOS_OFF_WAIT: begin
                  if (flag_active_i[i]) begin
                     state[i]            <= ccos_pkg::CCOS_FAULT;
                     channel_enable_o[i] <= 1'b0;
                  end else if (req[i]) begin
                     state[i] <= ccos_pkg::CCOS_RUN;
                  end else if (tmr_done[i]) begin
                     state[i]            <= ccos_pkg::CCOS_IDLE;
                     channel_enable_o[i] <= 1'b0;
                  end
               end
               ccos_pkg::CCOS_FAULT: begin
                  if (reenable_done_i[i] && !flag_active_i[i]) begin
                     if (!req[i]) begin
                        state[i] <= ccos_pkg::CCOS_IDLE;
                     end else if (extra[i]) begin
                        state[i] <= ccos_pkg::CCOS_EXTRA_WAIT;
                     end else begin
                        state[i]            <= ccos_pkg::CCOS_RUN;
                        channel_enable_o[i] <= 1'b1;
                        soft_start_o[i]     <= 1'b1;
                     end
                  end
               end
               ccos_pkg::CCOS_EXTRA_WAIT: begin
                  if (!req[i]) begin
                     state[i] <= ccos_pkg::CCOS_IDLE;
                  end else if (flag_active_i[i]) begin
                     state[i] <= ccos_pkg::CCOS_FAULT;
                  end else if (tmr_done[i]) begin
                     state[i]            <= ccos_pkg::CCOS_RUN;
                     channel_enable_o[i] <= 1'b1;
                     soft_start_o[i]     <= 1'b1;
                  end
               end
               default: begin
                  state[i]            <= ccos_pkg::CCOS_IDLE;
                  channel_enable_o[i] <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule // ccos_sequencer

// ---- verif/ccos_sequencer_sva.sv ----
`timescale 1ns/10ps
`include "ccos_regs.svh"
module ccos_sequencer_sva #(
   parameter int unsigned            CNT_W     = `CCOS_CNT_W,
   parameter logic [`CCOS_CNT_W-1:0] SHORT_CYC = `CCOS_CNT_W'(5),
   parameter logic [`CCOS_CNT_W-1:0] MID_CYC   = `CCOS_CNT_W'(9),
   parameter logic [`CCOS_CNT_W-1:0] LONG_CYC  = `CCOS_CNT_W'(17)
) (
   input wire logic                    clk_sys_i,
   input wire logic                    rst_i,
   input wire logic                    ce_i,
   input wire logic [`CCOS_ADDR_W-1:0] addr_i,
   input wire logic [7:0]              wdata_i,
   input wire logic                    wr_i,
   input wire logic                    rd_i,
   input wire logic [7:0]              rdata_o,
   input wire logic                    first_channel_on_pin_i,
   input wire logic                    second_channel_on_pin_i,
   input wire logic [2:0]              flag_active_i,
   input wire logic [2:0]              reenable_done_i,
   input wire logic [2:0]              channel_enable_o,
   input wire logic [2:0]              soft_start_o,
   input wire logic                    third_channel_on_request_o
);
   ccos_pkg::ccos_c_cfg_t cfg;
   int unsigned           on_cnt;
   int unsigned           off_cnt;
   logic                  c_flt;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   function automatic int unsigned cyc_of(input logic [1:0] code);
      case (code)
         `CCOS_DLY_SHORT: cyc_of = int'(SHORT_CYC);
         `CCOS_DLY_MID:   cyc_of = int'(MID_CYC);
         `CCOS_DLY_LONG:  cyc_of = int'(LONG_CYC);
         default:         cyc_of = 0;
      endcase
   endfunction

   // Shadow of the third channel setting, tracked from the write port
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) cfg <= `CCOS_RST_THIRD_CFG;
      else if (ce_i && wr_i && addr_i == `CCOS_ADDR_THIRD_CFG) cfg <= wdata_i;
   end
   // Cycles spent waiting to start and waiting to stop
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !third_channel_on_request_o || channel_enable_o[2] || flag_active_i[2]) on_cnt <= 0;
      else on_cnt <= on_cnt + 1;
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || third_channel_on_request_o || !channel_enable_o[2]) off_cnt <= 0;
      else off_cnt <= off_cnt + 1;
   end
   // Fault recovery starts are timed by the re-enable path, not the on wait
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) c_flt <= 1'b0;
      else if (flag_active_i[2]) c_flt <= 1'b1;
      else if (soft_start_o[2]) c_flt <= 1'b0;
   end

   property p_src_always;
      !cfg.src_sel [*4] |-> third_channel_on_request_o;
   endproperty
   a_src_always: assert property (p_src_always)
      else $error("third channel request low while always on");
   property p_ss_edge;
      soft_start_o == (channel_enable_o & ~$past(channel_enable_o));
   endproperty
   a_ss_edge: assert property (p_ss_edge)
      else $error("soft start not aligned with enable rise");
   property p_on_dly;
      soft_start_o[2] && !c_flt |-> on_cnt >= cyc_of(cfg.on_dly) + 1 && on_cnt <= cyc_of(cfg.on_dly) + 3;
   endproperty
   a_on_dly: assert property (p_on_dly)
      else $error("third channel start delay wrong");
   property p_off_dly;
      $fell(channel_enable_o[2]) && !$past(flag_active_i[2]) |->
         off_cnt >= cyc_of(cfg.off_dly) + 1 && off_cnt <= cyc_of(cfg.off_dly) + 3;
   endproperty
   a_off_dly: assert property (p_off_dly)
      else $error("third channel off delay wrong");
   property p_ss_req;
      soft_start_o[2] |-> third_channel_on_request_o;
   endproperty
   a_ss_req: assert property (p_ss_req)
      else $error("third channel started without request");
   property p_flag_off;
      flag_active_i != 3'h0 |=> (channel_enable_o & $past(flag_active_i)) == 3'h0;
   endproperty
   a_flag_off: assert property (p_flag_off)
      else $error("channel still enabled after flag");
   property p_rd_cfg;
      rd_i && ce_i && addr_i == `CCOS_ADDR_THIRD_CFG |=> rdata_o == cfg;
   endproperty
   a_rd_cfg: assert property (p_rd_cfg)
      else $error("third channel setting read back wrong");
   property p_rd_idle;
      !$past(rd_i) |-> rdata_o == `CCOS_RDATA_IDLE;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not idle");
endmodule // ccos_sequencer_sva

bind ccos_sequencer ccos_sequencer_sva #(.CNT_W(CNT_W), .SHORT_CYC(SHORT_CYC), .MID_CYC(MID_CYC),
   .LONG_CYC(LONG_CYC)) u_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .first_channel_on_pin_i(first_channel_on_pin_i), .second_channel_on_pin_i(second_channel_on_pin_i),
   .flag_active_i(flag_active_i), .reenable_done_i(reenable_done_i),
   .channel_enable_o(channel_enable_o), .soft_start_o(soft_start_o),
   .third_channel_on_request_o(third_channel_on_request_o));

// ---- verif/ccos_sequencer_tb.sv ----
`timescale 1ns/10ps
`include "ccos_regs.svh"
module ccos_sequencer_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        wr_s = 1'b0;
   logic        rd_s = 1'b0;
   logic        pin_a = 1'b0;
   logic        pin_b = 1'b0;
   logic [2:0]  flag = 3'h0;
   logic [2:0]  redone = 3'h0;
   logic [7:0]  rdata;
   logic [2:0]  en;
   logic [2:0]  ss;
   logic        req_c;
   logic [7:0]  d;
   int          n_fail = 0;
   int          n_checks = 0;
   int          dly[4] = '{0, 5, 9, 17};
   int          n[4];
   int          m[4];
   int          e[2];

   always #50 clk = ~clk;

   ccos_sequencer #(.SHORT_CYC(24'h5), .MID_CYC(24'h9), .LONG_CYC(24'h11)) dut (
      .clk_sys_i(clk), .rst_i(rst), .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
      .rd_i(rd_s), .rdata_o(rdata), .first_channel_on_pin_i(pin_a), .second_channel_on_pin_i(pin_b),
      .flag_active_i(flag), .reenable_done_i(redone), .channel_enable_o(en), .soft_start_o(ss),
      .third_channel_on_request_o(req_c));

   task test_done;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] x, input string msg);
      n_checks++;
      if (s !== x) begin
         n_fail++;
         $display("[FAIL] %0t %s seen %0h exp %0h", $time, msg, s, x);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk) begin addr <= a; wdata <= v; wr_s <= 1'b1; end
      @(posedge clk) wr_s <= 1'b0;
   endtask
   // Plain read: leaves the returned byte in d
   task rd(input logic [15:0] a);
      @(posedge clk) begin addr <= a; rd_s <= 1'b1; end
      @(posedge clk) rd_s <= 1'b0;
      #1 d = rdata;
   endtask
   task rdc(input logic [15:0] a, input logic [7:0] x, input string msg);
      rd(a);
      chk(d, x, msg);
   endtask
   // Counts edges until a start pulse, or until the channel is off
   task meas(input int ch, input bit off, output int cnt);
      cnt = 0;
      #1;
      while (off ? en[ch] !== 1'b0 : ss[ch] !== 1'b1) begin
         @(posedge clk) #1 cnt++;
         if (cnt > 200) begin
            chk(0, 1, "wait limit");
            test_done();
         end
      end
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rdc(`CCOS_ADDR_FIRST_CFG, `CCOS_RST_FIRST_CFG, "first reset");
      rdc(`CCOS_ADDR_THIRD_CFG, `CCOS_RST_THIRD_CFG, "third reset");
      wr(16'h0000, 8'hff);
      rdc(16'h0000, 8'h00, "unmapped");
      $display("test registers done");
      wr(`CCOS_ADDR_SECOND_CFG, 8'h14);
      wr(`CCOS_ADDR_FIRST_CFG, 8'h20);
      wr(`CCOS_ADDR_THIRD_CFG, 8'h10);
      repeat (10) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
         wr(`CCOS_ADDR_THIRD_CFG, {4'h1, 2'(k), 2'(k)});
         repeat (4) @(posedge clk);
         wr(`CCOS_ADDR_FIRST_CFG, 8'h60);
         meas(2, 1'b0, n[k]);
         wr(`CCOS_ADDR_FIRST_CFG, 8'h20);
         meas(2, 1'b1, m[k]);
      end
      for (int k = 1; k < 4; k++) begin
         chk(n[k] - n[0], dly[k], "on delay");
         chk(m[k] - m[0], dly[k], "off delay");
      end
      $display("test delays done");
      wr(`CCOS_ADDR_THIRD_CFG, 8'h1c);
      rdc(`CCOS_ADDR_THIRD_CFG, 8'h1c, "readback");
      wr(`CCOS_ADDR_FIRST_CFG, 8'h60);
      repeat (6) @(posedge clk);
      wr(`CCOS_ADDR_FIRST_CFG, 8'h20);
      repeat (3) @(posedge clk);
      wr(`CCOS_ADDR_FIRST_CFG, 8'h60);
      meas(2, 1'b0, e[0]);
      chk(e[0], n[3], "restart");
      wr(`CCOS_ADDR_FIRST_CFG, 8'h20);
      meas(2, 1'b1, e[0]);
      $display("test abort done");
      @(posedge clk) pin_b <= 1'b1;
      repeat (30) @(posedge clk);
      rdc(`CCOS_ADDR_STATUS, 8'h36, "either request");
      chk(req_c, 1'b1, "third request out");
      wr(`CCOS_ADDR_THIRD_CFG, 8'h00);
      @(posedge clk) pin_b <= 1'b0;
      repeat (30) @(posedge clk);
      rdc(`CCOS_ADDR_STATUS, 8'h24, "always on");
      chk(req_c, 1'b1, "always on out");
      for (int s = 0; s < 4; s++) begin
         for (int p = 0; p < 4; p++) begin
            wr(`CCOS_ADDR_FIRST_CFG, {1'b0, p[1], s[1:0], 4'h0});
            @(posedge clk) pin_a <= p[0];
            repeat (4) @(posedge clk);
            rd(`CCOS_ADDR_STATUS);
            chk(d[3], (s == 0) | (s == 1 & p[0]) | (s == 2 & p[1]) | (s == 3 & p[0] & p[1]),
                "first request");
         end
      end
      $display("test requests done");
      wr(`CCOS_ADDR_FIRST_CFG, 8'h64);
      @(posedge clk) pin_b <= 1'b1;
      for (int ch = 0; ch < 3; ch++) begin
         for (int x = 0; x < 2; x++) begin
            wr(`CCOS_ADDR_THIRD_CFG, {x == 1 && ch == 2, x == 1 && ch == 1, x == 1 && ch == 0, 5'h14});
            repeat (40) @(posedge clk);
            @(posedge clk) flag[ch] <= 1'b1;
            repeat (3) @(posedge clk);
            #1 chk(en[ch], 1'b0, "flag stop");
            @(posedge clk) flag[ch] <= 1'b0;
            @(posedge clk) redone[ch] <= 1'b1;
            @(posedge clk) redone[ch] <= 1'b0;
            meas(ch, 1'b0, e[x]);
         end
         chk(e[1] - e[0] >= 5 && e[1] - e[0] <= 7, 1, "extra delay");
      end
      $display("test re-enable done");
      test_done();
   end
endmodule // ccos_sequencer_tb
